// ### hdl/adc_fifo_host_pkg.sv
// constants shared by the converter back end: register layout, reset values, codes and trigger levels
//
// Overview of operation
// - single-ended binary: top FFFh, mid 800h, bottom 000h
// - single-ended twos complement: top 7FFh, mid 000h, bottom 800h
// - differential binary: +span FFFh, zero 800h, -span 000h
// - differential twos complement: +span 7FFh, zero 000h, -span 800h
// - sixteen-entry circular buffer, filled without host action
// - read pointer names the next location delivered
// - write pointer and trigger pointer are kept
// - samples stored in sweep order, block starts first channel
// - data-available fires when written count reaches trigger level
// - data-available is an active-low pulse per block
// - single input: trigger levels 1, 4, 8, 14
// - read strobe combines both selects and read
// - two 10-bit configuration registers
// - first register layout, bit 9 down to 0
// - second register layout, bit 9 down to 0
// - address 00 first, 01 second, bit 11 set reserved
// - test select active suppresses data-available
// - host access and draining work during power-down
package adc_fifo_host_pkg;

    // ------------------------------------------------------------
    // bus and register geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 12;               // host data bus and sample width
    localparam int REG_W = 10;                // configuration register width
    localparam int ADDR_LO_BIT = 10;          // reg_select_lo on the data bus
    localparam int ADDR_HI_BIT = 11;          // reg_select_hi on the data bus
    localparam int SYNC_STAGES = 2;           // pin synchroniser depth
    localparam int BUFFER_DEPTH = 16;         // circular sample buffer entries
    localparam int STAGING_DEPTH = 32;        // staging fifo in front of the buffer

    // ------------------------------------------------------------
    // register address codes
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_SETUP = 2'h0;   // converter_setup_word
    localparam logic [1:0] ADDR_BUFFER = 2'h1;  // buffer_and_output_setup_word

    // ------------------------------------------------------------
    // converter_setup_word fields
    // ------------------------------------------------------------
    localparam int SETUP_REFSEL_BIT = 0;       // reference source select
    localparam int SETUP_MODE_BIT = 1;         // conversion mode
    localparam int SETUP_POWERDOWN_BIT = 2;    // powerdown
    localparam int SETUP_PICK_LO_BIT = 3;      // input_pick_lo
    localparam int SETUP_PICK_HI_BIT = 4;      // input_pick_hi
    localparam int SETUP_PAIR_LO_BIT = 5;      // balanced_pair_count_lo
    localparam int SETUP_PAIR_HI_BIT = 6;      // balanced_pair_count_hi
    localparam int SETUP_SWEEP_BIT = 7;        // auto-sweep enable
    localparam int SETUP_CHECK_LO_BIT = 8;     // selfcheck_sel_lo
    localparam int SETUP_CHECK_HI_BIT = 9;     // selfcheck_sel_hi
    localparam logic [9:0] SETUP_RESET = 10'h020;

    // ------------------------------------------------------------
    // buffer_and_output_setup_word fields
    // ------------------------------------------------------------
    localparam int BUF_SOFT_RESET_BIT = 0;     // reset, self clearing
    localparam int BUF_CLEAR_BIT = 1;          // overflow_buffer_clear, self clearing
    localparam int BUF_THR_LO_BIT = 2;         // fill_threshold_lo
    localparam int BUF_THR_HI_BIT = 3;         // fill_threshold_hi
    localparam int BUF_AV_TYPE_BIT = 4;        // data-available type
    localparam int BUF_AV_POL_BIT = 5;         // data-available polarity
    localparam int BUF_RW_BIT = 6;             // read/write select
    localparam int BUF_FORMAT_BIT = 7;         // output_code_format, 1 = twos complement
    localparam int BUF_OFFSET_BIT = 8;         // offset
    localparam int BUF_ECHO_BIT = 9;           // config_echo_enable
    localparam logic [9:0] BUF_RESET = 10'h000;
    localparam logic [9:0] BUF_SELF_CLEAR_MASK = 10'h003;

    // ------------------------------------------------------------
    // output codes and trigger levels
    // ------------------------------------------------------------
    localparam logic [11:0] TWOS_FLIP_MASK = 12'h800;  // offset binary to twos complement
    localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
    localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
    localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
    localparam logic [4:0] TRIG_LEVEL_3 = 5'h0E;

endpackage

// ### hdl/adc_fifo_host_interface.sv
// sample fifo and host-side back end of the four-input converter
`timescale 1ns/1ps

// ------------------------------------------------------------
// generic fifo with pointer wrap, used as staging and as the circular buffer
// ------------------------------------------------------------
module sample_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data,
    output logic [$clog2(DEPTH)-1:0] o_wr_ptr,
    output logic [$clog2(DEPTH)-1:0] o_rd_ptr
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];   // storage, no reset needed
    logic [AW-1:0] wr_ptr_q;         // next location written
    logic [AW-1:0] rd_ptr_q;         // next location read
    logic [AW:0] count_q;            // entries held
    logic [AW:0] count_d;
    logic ready_q;                   // registered not-full, so ready comes straight from a flop
    logic valid_q;                   // registered not-empty
    logic push;
    logic pop;

    assign push = i_valid && ready_q;
    assign pop = valid_q && i_ready;
    assign o_ready = ready_q;
    assign o_valid = valid_q;
    assign o_data = mem[rd_ptr_q];
    assign o_wr_ptr = wr_ptr_q;
    assign o_rd_ptr = rd_ptr_q;

    // occupancy after this cycle's traffic
    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (AW+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (AW+1)'(1);
        end
    end

    // storage write; clear only moves pointers, data may stay
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr_q] <= i_data;
        end
    end

    // pointers step by one and wrap from the last entry to zero
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (i_clear) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + AW'(1);
            end
        end
    end

    // occupancy, not-full and not-empty flags
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= '0;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
        end else if (i_clear) begin
            count_q <= '0;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            count_q <= count_d;
            ready_q <= (count_d != (AW+1)'(DEPTH));
            valid_q <= (count_d != '0);
        end
    end
endmodule // sample_fifo

// ------------------------------------------------------------
// top: host strobes, configuration registers, buffer and data-available
// ------------------------------------------------------------
module adc_fifo_host_interface
    import adc_fifo_host_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_select_a_n,                // first chip select, pin
    input wire logic i_select_b,                  // second chip select, pin
    input wire logic i_read_n,                    // read strobe pin
    input wire logic i_write_n,                   // write strobe pin
    input wire logic [DATA_W-1:0] i_data,         // data bus, as seen at the pins
    output logic [DATA_W-1:0] o_data,             // data bus drive value
    output logic o_data_oe,                       // high while the block drives the bus
    output logic o_sample_block_ready_n,          // data-available pulse
    input wire logic i_sample_valid,              // converter result, same clock
    input wire logic [DATA_W-1:0] i_sample_code,  // offset binary result
    output logic o_sample_ready,                  // staging can take a result
    output logic [REG_W-1:0] o_converter_setup    // setup word to the analog side
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] sel_a_n_sync;   // one shift chain per pin
    logic [SYNC_STAGES-1:0] sel_b_sync;
    logic [SYNC_STAGES-1:0] rd_n_sync;
    logic [SYNC_STAGES-1:0] wr_n_sync;
    logic [DATA_W-1:0] data_meta_q;          // first stage, only the second reads it
    logic [DATA_W-1:0] data_sync_q;

    // two flops per pin before any logic sees them
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_a_n_sync <= '1;
            sel_b_sync <= '0;
            rd_n_sync <= '1;
            wr_n_sync <= '1;
            data_meta_q <= '0;
            data_sync_q <= '0;
        end else begin
            sel_a_n_sync <= {sel_a_n_sync[SYNC_STAGES-2:0], i_select_a_n};
            sel_b_sync <= {sel_b_sync[SYNC_STAGES-2:0], i_select_b};
            rd_n_sync <= {rd_n_sync[SYNC_STAGES-2:0], i_read_n};
            wr_n_sync <= {wr_n_sync[SYNC_STAGES-2:0], i_write_n};
            data_meta_q <= i_data;
            data_sync_q <= data_meta_q;
        end
    end

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    logic selected;        // both selects in their active state
    logic read_active;     // internal read strobe
    logic write_active;    // internal write strobe
    logic read_prev_q;     // for edge detect on the synchronised strobe
    logic write_prev_q;
    logic read_rise;
    logic write_rise;

    assign selected = !sel_a_n_sync[SYNC_STAGES-1] && sel_b_sync[SYNC_STAGES-1];
    assign read_active = selected && !rd_n_sync[SYNC_STAGES-1];
    assign write_active = selected && !wr_n_sync[SYNC_STAGES-1];
    assign read_rise = read_active && !read_prev_q;
    assign write_rise = write_active && !write_prev_q;

    // remember last strobe levels; one access per strobe, however long it lasts
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_prev_q <= 1'b0;
            write_prev_q <= 1'b0;
        end else begin
            read_prev_q <= read_active;
            write_prev_q <= write_active;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [REG_W-1:0] setup_q;     // converter_setup_word
    logic [REG_W-1:0] buffer_q;    // buffer_and_output_setup_word, self-clearing bits held zero
    logic [1:0] wr_addr;           // reg_select_hi, reg_select_lo
    logic [REG_W-1:0] wr_value;
    logic clear_q;                 // one-cycle buffer clear
    logic soft_reset;

    assign wr_addr = {data_sync_q[ADDR_HI_BIT], data_sync_q[ADDR_LO_BIT]};
    assign wr_value = data_sync_q[REG_W-1:0];
    assign soft_reset = write_rise && (wr_addr == ADDR_BUFFER) && wr_value[BUF_SOFT_RESET_BIT];

    // register writes; reserved addresses are dropped without effect
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            setup_q <= SETUP_RESET;
            buffer_q <= BUF_RESET;
        end else if (soft_reset) begin
            setup_q <= SETUP_RESET;
            buffer_q <= BUF_RESET;
        end else if (write_rise && (wr_addr == ADDR_SETUP)) begin
            setup_q <= wr_value;
        end else if (write_rise && (wr_addr == ADDR_BUFFER)) begin
            buffer_q <= wr_value & ~BUF_SELF_CLEAR_MASK;
        end
    end

    // buffer clear pulse from either self-clearing bit of the second word
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clear_q <= 1'b0;
        end else begin
            clear_q <= write_rise && (wr_addr == ADDR_BUFFER) && (wr_value[BUF_CLEAR_BIT] || soft_reset);
        end
    end

    // setup word to the analog side, straight from the register
    assign o_converter_setup = setup_q;

    // ------------------------------------------------------------
    // staging fifo and circular buffer
    // ------------------------------------------------------------
    logic stage_valid;
    logic [DATA_W-1:0] stage_data;
    logic circ_ready;
    logic circ_valid;
    logic [DATA_W-1:0] circ_data;
    logic [$clog2(BUFFER_DEPTH)-1:0] circ_wr_ptr;   // next slot; last written is one behind
    logic [$clog2(BUFFER_DEPTH)-1:0] circ_rd_ptr;   // next slot delivered to the host
    logic circ_push;
    logic circ_pop;

    // staging absorbs bursts while the host is slow; its ready is the converter's stall
    sample_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(STAGING_DEPTH)
    ) u_staging (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clear(1'b0),
        .i_valid(i_sample_valid),
        .o_ready(o_sample_ready),
        .i_data(i_sample_code),
        .o_valid(stage_valid),
        .i_ready(circ_ready),
        .o_data(stage_data),
        .o_wr_ptr(),
        .o_rd_ptr()
    );

    // results enter in arrival order, which is the sweep order
    sample_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(BUFFER_DEPTH)
    ) u_circular (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clear(clear_q),
        .i_valid(stage_valid),
        .o_ready(circ_ready),
        .i_data(stage_data),
        .o_valid(circ_valid),
        .i_ready(read_rise),
        .o_data(circ_data),
        .o_wr_ptr(circ_wr_ptr),
        .o_rd_ptr(circ_rd_ptr)
    );

    assign circ_push = stage_valid && circ_ready;
    assign circ_pop = circ_valid && read_rise;

    // ------------------------------------------------------------
    // trigger pointer and data-available pulse
    // ------------------------------------------------------------
    logic [4:0] trig_level;     // values per block
    logic [4:0] trig_count_q;   // trigger pointer: values written since last block
    logic trig_fire;
    logic selfcheck_on;
    logic ready_n_q;

    // only the single-input level set is decoded; other input counts reuse it
    always_comb begin
        case ({buffer_q[BUF_THR_HI_BIT], buffer_q[BUF_THR_LO_BIT]})
            2'h0: trig_level = TRIG_LEVEL_0;
            2'h1: trig_level = TRIG_LEVEL_1;
            2'h2: trig_level = TRIG_LEVEL_2;
            default: trig_level = TRIG_LEVEL_3;
        endcase
    end

    assign trig_fire = circ_push && ((trig_count_q + 5'h01) >= trig_level);
    assign selfcheck_on = setup_q[SETUP_CHECK_HI_BIT] || setup_q[SETUP_CHECK_LO_BIT];

    // count written values; restart on each block and on buffer clear
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trig_count_q <= '0;
        end else if (clear_q) begin
            trig_count_q <= '0;
        end else if (trig_fire) begin
            trig_count_q <= '0;
        end else if (circ_push) begin
            trig_count_q <= trig_count_q + 5'h01;
        end
    end

    // one-cycle low pulse per block, held high while a test input is selected
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ready_n_q <= 1'b1;
        end else begin
            ready_n_q <= !(trig_fire && !selfcheck_on);
        end
    end

    assign o_sample_block_ready_n = ready_n_q;

    // ------------------------------------------------------------
    // host read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] fmt_mask;
    logic [DATA_W-1:0] data_q;
    logic oe_q;

    // straight binary is the native code; twos complement flips the top bit
    assign fmt_mask = buffer_q[BUF_FORMAT_BIT] ? TWOS_FLIP_MASK : '0;

    // latch one sample per read strobe; powerdown does not gate this
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_q <= '0;
        end else if (circ_pop) begin
            data_q <= circ_data ^ fmt_mask;
        end
    end

    // drive the bus while the read strobe is active
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= read_active;
        end
    end

    assign o_data = data_q;
    assign o_data_oe = oe_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    property p_read_format;
        circ_pop |=> (o_data == ($past(circ_data) ^ $past(fmt_mask)));
    endproperty
    a_read_format: assert property (p_read_format) else $error("read data not formatted");

    property p_twos_top;
        circ_pop && (circ_data == 12'hFFF) && buffer_q[BUF_FORMAT_BIT] |=> (o_data == 12'h7FF);
    endproperty
    a_twos_top: assert property (p_twos_top) else $error("twos top code wrong");

    property p_read_advance;
        circ_pop |=> (circ_rd_ptr == ($past(circ_rd_ptr) + 4'h1)) || clear_q || $past(clear_q);
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("read pointer did not step");

    property p_pulse;
        !o_sample_block_ready_n |=> o_sample_block_ready_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready not a pulse");

    property p_trigger;
        trig_fire && !selfcheck_on |=> !o_sample_block_ready_n;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger missed");

    property p_selfcheck;
        selfcheck_on |=> o_sample_block_ready_n;
    endproperty
    a_selfcheck: assert property (p_selfcheck) else $error("ready during test");

    property p_write_setup;
        write_rise && (wr_addr == ADDR_SETUP) |=> (setup_q == $past(wr_value));
    endproperty
    a_write_setup: assert property (p_write_setup) else $error("setup write lost");

    property p_reserved;
        write_rise && wr_addr[1] |=> $stable(setup_q) && $stable(buffer_q);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved write took effect");

    property p_clear;
        clear_q |=> !circ_valid && (trig_count_q == 5'h00) && (circ_wr_ptr == 4'h0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear left data");

    property p_oe;
        read_active |=> o_data_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("bus not driven during read");

endmodule // adc_fifo_host_interface

// ### verif/host_bus_model.sv
// host processor model driving the parallel strobes and data bus
`timescale 1ns/1ps

module host_bus_model (
    input wire logic i_clock,
    input wire logic [11:0] i_bus,
    output logic o_select_a_n,
    output logic o_select_b,
    output logic o_read_n,
    output logic o_write_n,
    output logic [11:0] o_data
);
    // idle: not selected, data shows a changing pattern, not the last value
    initial begin
        o_select_a_n = 1'b1;
        o_select_b = 1'b0;
        o_read_n = 1'b1;
        o_write_n = 1'b1;
        o_data = 12'hA5A;
    end

    // ------------------------------------------------------------
    // one bus access; value on bits 9:0, address on 11:10
    // ------------------------------------------------------------
    task automatic access(input logic rd, input logic [11:0] d, output logic [11:0] q);
        @(negedge i_clock);
        o_data = d;
        @(negedge i_clock);
        o_select_a_n = 1'b0;
        o_select_b = 1'b1;
        o_read_n = !rd;
        o_write_n = rd;
        // four clocks low covers the two-stage synchroniser plus answer
        repeat (4) @(negedge i_clock);
        q = i_bus;
        o_select_a_n = 1'b1;
        o_select_b = 1'b0;
        o_read_n = 1'b1;
        o_write_n = 1'b1;
        // data held past the strobe, then spacing before the next access
        repeat (4) @(negedge i_clock);
        o_data = ~o_data;
    endtask
endmodule // host_bus_model

// ### verif/adc_fifo_host_interface_test.sv
// self-checking bench for the converter back end
`timescale 1ns/1ps

module adc_fifo_host_interface_test;
    import adc_fifo_host_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic s_valid = 1'b0;
    logic [11:0] s_code = 12'h000;
    logic sel_a_n, sel_b, rd_n, wr_n, dut_oe, ready_n, s_ready;
    logic [11:0] host_d, bus, dut_d;
    logic [9:0] setup;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int pulses = 0;
    int lv[4] = '{1, 4, 8, 14};
    logic [11:0] mem[$];

    always #20 i_clock = ~i_clock;
    // bus level: the block wins while it drives, otherwise the host
    assign bus = dut_oe ? dut_d : host_d;

    host_bus_model host (.i_clock(i_clock), .i_bus(bus), .o_select_a_n(sel_a_n), .o_select_b(sel_b),
        .o_read_n(rd_n), .o_write_n(wr_n), .o_data(host_d));
    adc_fifo_host_interface dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_select_a_n(sel_a_n),
        .i_select_b(sel_b), .i_read_n(rd_n), .i_write_n(wr_n), .i_data(bus), .o_data(dut_d),
        .o_data_oe(dut_oe), .o_sample_block_ready_n(ready_n), .i_sample_valid(s_valid),
        .i_sample_code(s_code), .o_sample_ready(s_ready), .o_converter_setup(setup));

    // ------------------------------------------------------------
    // pulse counter and hang guard
    // ------------------------------------------------------------
    // sampled at the falling edge, where the registered pulse has settled
    always @(negedge i_clock) begin
        cycles++;
        if (ready_n === 1'b0) pulses++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // twos complement flips only the top bit of the offset-binary code
    function automatic logic [11:0] fmt(input logic [11:0] c, input logic tw);
        return tw ? (c ^ 12'h800) : c;
    endfunction

    // converter results pushed back to back; corners first
    task automatic push(input int n);
        logic [11:0] c;
        for (int i = 0; i < n; i++) begin
            @(negedge i_clock);
            c = (i == 0) ? 12'hFFF : (i == 1) ? 12'h800 : (i == 2) ? 12'h000 : 12'($urandom);
            s_valid = 1'b1;
            s_code = c;
            mem.push_back(c);
        end
        @(negedge i_clock);
        s_valid = 1'b0;
    endtask

    // host drains one block and compares the formatted codes
    task automatic drain(input int n, input logic tw);
        logic [11:0] q;
        for (int i = 0; i < n; i++) begin
            host.access(1'b1, 12'h000, q);
            check(q, fmt(mem.pop_front(), tw));
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        logic [11:0] q;
        logic [9:0] v;
        void'($urandom(76));
        repeat (16) @(posedge i_clock);
        @(negedge i_clock);
        i_rst_n = 1'b1;
        check({2'h0, setup}, 12'h020);
        check({11'h000, ready_n}, 12'h001);
        check({11'h000, s_ready}, 12'h001);
        // random setup word, powered down so draining runs in power-down
        v = 10'($urandom_range(0, 255)) | 10'h004;
        host.access(1'b0, {2'h0, v}, q);
        check({2'h0, setup}, {2'h0, v});
        host.access(1'b0, {2'h2, ~v}, q);
        check({2'h0, setup}, {2'h0, v});
        // every trigger code in both formats, two blocks each so 14 wraps
        for (int k = 0; k < 4; k++) begin
            for (int t = 0; t < 2; t++) begin
                host.access(1'b0, {2'h1, 2'h0, t[0], 3'h0, k[1:0], 2'h2}, q);
                for (int b = 0; b < 2; b++) begin
                    pulses = 0;
                    push(lv[k]);
                    repeat (6) @(negedge i_clock);
                    check(12'(pulses), 12'h001);
                    drain(lv[k], t[0]);
                end
            end
        end
        // self-check selection mutes the ready pulse; data still readable
        host.access(1'b0, {2'h1, 10'h002}, q);
        host.access(1'b0, {2'h0, 10'h100}, q);
        pulses = 0;
        push(1);
        repeat (6) @(negedge i_clock);
        check(12'(pulses), 12'h000);
        drain(1, 1'b0);
        conclude();
    end
endmodule // adc_fifo_host_interface_test
